//--- hw/bfl_consts.svh
// Register map, field positions, reset values and timing counts of the
// bar feeder lathe interface.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
`ifndef BFL_CONSTS_SVH
`define BFL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BFL_ADDR_W 8
`define BFL_CTRL_OFFS 8'h00
`define BFL_STATUS_OFFS 8'h04

// ----------------------------------------------------------------------
// Control register layout and reset value
// ----------------------------------------------------------------------
`define BFL_CTRL_W 6
`define BFL_CTRL_RESET 6'h22
`define BFL_CTRL_EOB_LSB 2
`define BFL_EOB_ILLEGAL 2'h3

// ----------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------
`define BFL_STATUS_W 10

// ----------------------------------------------------------------------
// Lathe input bit positions in the synchronised vector
// ----------------------------------------------------------------------
`define BFL_PIN_W 7
`define BFL_PIN_FEED 0
`define BFL_PIN_EJECT 1
`define BFL_PIN_CLAMP 2
`define BFL_PIN_ATPOS 3
`define BFL_PIN_SHORT 4
`define BFL_PIN_EJDONE 5
`define BFL_PIN_MDONE 6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BFL_CLK_FREQ_KHZ 20000
`define BFL_MFIN_TIME_MS 500
`define BFL_DWELL_TIME_MS 200
`define BFL_MFIN_CYCLES (`BFL_MFIN_TIME_MS * `BFL_CLK_FREQ_KHZ)
`define BFL_MFIN_CNT_W 24

`endif

//--- hw/bfl_pkg.sv
// Types shared by the bar feeder lathe interface modules.
// Assumes the constants header is compiled alongside.
package bfl_pkg;

  // --------------------------------------------------------------------
  // End-of-bar timing style
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    EOB_SHORT,
    EOB_LONG,
    EOB_STANDARD
  } bfl_eob_type;

  // --------------------------------------------------------------------
  // Software configuration, laid out as the control register
  // --------------------------------------------------------------------
  typedef struct packed {
    logic mfin_static;
    logic clamp_inv;
    bfl_eob_type eob_style;
    logic mcode_en;
    logic test_mode;
  } bfl_cfg_type;

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FEED,
    ST_HOLD,
    ST_EJECT,
    ST_T_PUSH,
    ST_T_RETURN,
    ST_T_CH_UP,
    ST_T_FLAG_FWD,
    ST_T_FLAG_BACK,
    ST_T_CH_DOWN
  } bfl_state_type;

endpackage

//--- hw/bfl_sync_edge.sv
// Two-stage synchroniser with rise and fall detection for lathe inputs.
// Assumes the inputs are asynchronous to CLK_I.
`timescale 1ns/1ps
`default_nettype none
module bfl_sync_edge #(
  parameter int unsigned WIDTH = 7
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // Only the second stage and its delayed copy feed any logic.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_comb
  begin
    level_o = sync_q;
    rise_o = sync_q & ~prev_q;
    fall_o = ~sync_q & prev_q;
  end

  a_rise_is_edge: assert property (
    @(posedge clk_i) disable iff (reset_i)
    rise_o == (sync_q & ~$past(sync_q)))
    else $error("rise flag does not match a low to high step");
endmodule
`default_nettype wire

//--- hw/bfl_mfin_gen.sv
// Command-finished pulse generator, dynamic or static style.
// Assumes start_i is a one-cycle pulse and cmd_i is already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "bfl_consts.svh"
module bfl_mfin_gen #(
  parameter int unsigned CYCLES = `BFL_MFIN_CYCLES,
  parameter int unsigned CNT_W = `BFL_MFIN_CNT_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic static_i,
  input wire logic cmd_i,
  output logic mfin_o
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] high_q;

  // A static pulse never starts or stays up once the lathe drops its
  // command, so the lathe never sees a finish it did not ask for.
  always_comb
  begin
    if (static_i && !cmd_i)
      cnt_d = '0;
    else if (start_i)
      cnt_d = CNT_W'(CYCLES);
    else if (cnt_q != '0)
      cnt_d = cnt_q - CNT_W'(1);
    else
      cnt_d = '0;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_q <= '0;
      mfin_o <= 1'b0;
      high_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      mfin_o <= (cnt_d != '0);
      high_q <= (cnt_d != '0) ? high_q + CNT_W'(1) : '0;
    end
  end

  a_mfin_dyn_len: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $fell(mfin_o) && !$past(static_i) && !$past(start_i)
      |-> $past(high_q) == CNT_W'(CYCLES))
    else $error("dynamic finish pulse has the wrong length");

  a_mfin_static_cut: assert property (
    @(posedge clk_i) disable iff (reset_i)
    mfin_o && static_i && !cmd_i && !start_i |=> !mfin_o)
    else $error("static finish stayed high without the command");

  a_mfin_max_len: assert property (
    @(posedge clk_i) disable iff (reset_i)
    high_q <= CNT_W'(CYCLES))
    else $error("finish pulse ran past its limit");
endmodule
`default_nettype wire

//--- hw/bfl_feeder_if.sv
// Top of the bar feeder lathe interface: APB registers, feed sequencer,
// test running-in sequencer, end-of-bar timing and clamp polarity.
// Assumes lathe pins are asynchronous and motion axes report completion.
`timescale 1ns/1ps
`default_nettype none
`include "bfl_consts.svh"
module bfl_feeder_if #(
  parameter int unsigned MFIN_CYCLES = `BFL_MFIN_CYCLES,
  parameter int unsigned CNT_W = `BFL_MFIN_CNT_W
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`BFL_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic FEED_CMD_I,
  input wire logic EJECT_CMD_I,
  input wire logic CLAMP_I,
  input wire logic AT_POSITION_I,
  input wire logic SHORT_BAR_I,
  input wire logic EJECT_DONE_I,
  input wire logic MOTION_DONE_I,
  output logic FEED_O,
  output logic EJECT_O,
  output logic MFIN_O,
  output logic EOB_O,
  output logic TEST_ACTIVE_O,
  output logic [2:0] MOTION_STEP_O
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_NONE} bfl_sel_type;

  function automatic bfl_sel_type reg_sel(
    input logic [`BFL_ADDR_W-1:0] addr
  );
    if (addr == `BFL_CTRL_OFFS)
      return SEL_CTRL;
    else if (addr == `BFL_STATUS_OFFS)
      return SEL_STATUS;
    else
      return SEL_NONE;
  endfunction

  function automatic logic [2:0] step_code(input bfl_pkg::bfl_state_type s);
    unique case (s)
      bfl_pkg::ST_T_PUSH: return 3'h1;
      bfl_pkg::ST_T_RETURN: return 3'h2;
      bfl_pkg::ST_T_CH_UP: return 3'h3;
      bfl_pkg::ST_T_FLAG_FWD: return 3'h4;
      bfl_pkg::ST_T_FLAG_BACK: return 3'h5;
      bfl_pkg::ST_T_CH_DOWN: return 3'h6;
      default: return 3'h0;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Lathe inputs
  // --------------------------------------------------------------------
  logic [`BFL_PIN_W-1:0] pin_lvl;
  logic [`BFL_PIN_W-1:0] pin_rise;
  logic [`BFL_PIN_W-1:0] pin_fall;

  bfl_sync_edge #(.WIDTH(`BFL_PIN_W)) u_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .pin_i({MOTION_DONE_I, EJECT_DONE_I, SHORT_BAR_I, AT_POSITION_I,
            CLAMP_I, EJECT_CMD_I, FEED_CMD_I}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  bfl_pkg::bfl_cfg_type cfg_q;
  bfl_pkg::bfl_cfg_type cfg_d;
  logic clamp_open;
  logic clamp_open_rise;

  always_comb
  begin
    clamp_open = pin_lvl[`BFL_PIN_CLAMP] ^ cfg_q.clamp_inv;
    clamp_open_rise = cfg_q.clamp_inv ? pin_fall[`BFL_PIN_CLAMP]
                                      : pin_rise[`BFL_PIN_CLAMP];
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  logic [31:0] prdata_d;
  logic [`BFL_STATUS_W-1:0] status;
  bfl_sel_type sel;
  logic access;

  always_comb
  begin
    sel = reg_sel(PADDR_I);
    access = PSEL_I && PENABLE_I;
    PREADY_O = 1'b1;
    PSLVERR_O = access && (sel == SEL_NONE);
    cfg_d = cfg_q;
    if (access && PWRITE_I && sel == SEL_CTRL)
    begin
      cfg_d = bfl_pkg::bfl_cfg_type'(PWDATA_I[`BFL_CTRL_W-1:0]);
      // An undefined style code keeps the style in force.
      if (PWDATA_I[`BFL_CTRL_EOB_LSB +: 2] == `BFL_EOB_ILLEGAL)
        cfg_d.eob_style = cfg_q.eob_style;
    end
    prdata_d = PRDATA_O;
    // Read data is captured in the setup cycle so it leaves a flop.
    if (PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      unique case (sel)
        SEL_CTRL: prdata_d = {{(32-`BFL_CTRL_W){1'b0}}, cfg_q};
        SEL_STATUS: prdata_d = {{(32-`BFL_STATUS_W){1'b0}}, status};
        SEL_NONE: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      cfg_q <= bfl_pkg::bfl_cfg_type'(`BFL_CTRL_RESET);
      PRDATA_O <= 32'h0000_0000;
    end
    else
    begin
      cfg_q <= cfg_d;
      PRDATA_O <= prdata_d;
    end
  end

  // --------------------------------------------------------------------
  // Feed, eject and test sequencer
  // --------------------------------------------------------------------
  bfl_pkg::bfl_state_type state_q;
  bfl_pkg::bfl_state_type state_d;
  logic mfin_start;
  logic motion_done;

  always_comb
  begin
    state_d = state_q;
    mfin_start = 1'b0;
    motion_done = pin_lvl[`BFL_PIN_MDONE];
    unique case (state_q)
      bfl_pkg::ST_IDLE:
        if (cfg_q.test_mode)
          state_d = bfl_pkg::ST_T_PUSH;
        else if (cfg_q.mcode_en ? pin_rise[`BFL_PIN_FEED] : clamp_open_rise)
          state_d = bfl_pkg::ST_FEED;
        else if (pin_rise[`BFL_PIN_EJECT])
          state_d = bfl_pkg::ST_EJECT;
      bfl_pkg::ST_FEED:
        if (cfg_q.mcode_en)
        begin
          if (pin_lvl[`BFL_PIN_ATPOS])
          begin
            state_d = bfl_pkg::ST_HOLD;
            mfin_start = 1'b1;
          end
        end
        else if (!clamp_open)
          state_d = bfl_pkg::ST_IDLE;
      bfl_pkg::ST_HOLD:
        if (!clamp_open)
          state_d = bfl_pkg::ST_IDLE;
      bfl_pkg::ST_EJECT:
        if (pin_lvl[`BFL_PIN_EJDONE])
        begin
          state_d = bfl_pkg::ST_IDLE;
          mfin_start = 1'b1;
        end
      bfl_pkg::ST_T_PUSH:
        if (motion_done)
          state_d = bfl_pkg::ST_T_RETURN;
      bfl_pkg::ST_T_RETURN:
        if (motion_done)
          state_d = bfl_pkg::ST_T_CH_UP;
      bfl_pkg::ST_T_CH_UP:
        if (motion_done)
          state_d = bfl_pkg::ST_T_FLAG_FWD;
      bfl_pkg::ST_T_FLAG_FWD:
        if (motion_done)
          state_d = bfl_pkg::ST_T_FLAG_BACK;
      bfl_pkg::ST_T_FLAG_BACK:
        if (motion_done)
          state_d = bfl_pkg::ST_T_CH_DOWN;
      bfl_pkg::ST_T_CH_DOWN:
        // Leaving test mode only takes effect at the end of a full cycle.
        if (motion_done)
          state_d = cfg_q.test_mode ? bfl_pkg::ST_T_PUSH
                                    : bfl_pkg::ST_IDLE;
      default:
        state_d = bfl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      state_q <= bfl_pkg::ST_IDLE;
      FEED_O <= 1'b0;
      EJECT_O <= 1'b0;
      MOTION_STEP_O <= 3'h0;
      TEST_ACTIVE_O <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      FEED_O <= (state_d == bfl_pkg::ST_FEED) ||
                (state_d == bfl_pkg::ST_HOLD);
      EJECT_O <= (state_d == bfl_pkg::ST_EJECT);
      MOTION_STEP_O <= step_code(state_d);
      TEST_ACTIVE_O <= (step_code(state_d) != 3'h0);
    end
  end

  // --------------------------------------------------------------------
  // Command-finished signal
  // --------------------------------------------------------------------
  bfl_mfin_gen #(.CYCLES(MFIN_CYCLES), .CNT_W(CNT_W)) u_mfin (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .start_i(mfin_start),
    .static_i(cfg_q.mfin_static),
    .cmd_i(pin_lvl[`BFL_PIN_FEED] | pin_lvl[`BFL_PIN_EJECT]),
    .mfin_o(MFIN_O)
  );

  // --------------------------------------------------------------------
  // End of bar
  // --------------------------------------------------------------------
  logic eob_q;
  logic eob_d;
  logic [1:0] fin_cnt_q;
  logic [1:0] fin_cnt_d;
  logic mfin_prev_q;
  logic mfin_rise;
  logic eob_out_d;

  always_comb
  begin
    mfin_rise = MFIN_O && !mfin_prev_q;
    eob_d = eob_q;
    fin_cnt_d = fin_cnt_q;
    if (cfg_q.eob_style == bfl_pkg::EOB_LONG && eob_q && mfin_rise)
    begin
      if (fin_cnt_q == 2'h1)
      begin
        eob_d = 1'b0;
        fin_cnt_d = 2'h0;
      end
      else
        fin_cnt_d = fin_cnt_q + 2'h1;
    end
    if (cfg_q.eob_style == bfl_pkg::EOB_STANDARD &&
        pin_rise[`BFL_PIN_EJECT])
      eob_d = 1'b0;
    // A new short bar wins over a clear in the same cycle.
    if (cfg_q.eob_style != bfl_pkg::EOB_SHORT &&
        pin_rise[`BFL_PIN_SHORT])
    begin
      eob_d = 1'b1;
      fin_cnt_d = 2'h0;
    end
    if (cfg_q.eob_style == bfl_pkg::EOB_SHORT)
    begin
      eob_d = 1'b0;
      fin_cnt_d = 2'h0;
      eob_out_d = pin_lvl[`BFL_PIN_SHORT] && !clamp_open;
    end
    else
      eob_out_d = eob_d;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      eob_q <= 1'b0;
      fin_cnt_q <= 2'h0;
      mfin_prev_q <= 1'b0;
      EOB_O <= 1'b0;
    end
    else
    begin
      eob_q <= eob_d;
      fin_cnt_q <= fin_cnt_d;
      mfin_prev_q <= MFIN_O;
      EOB_O <= eob_out_d;
    end
  end

  always_comb
  begin
    status = {TEST_ACTIVE_O, EJECT_O, clamp_open, EOB_O, MFIN_O, FEED_O,
              state_q};
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_feed_on_cmd: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    $rose(FEED_O) && $past(cfg_q.mcode_en) |-> $past(pin_rise[0]))
    else $error("feed began without a feed command");

  a_fin_at_pos: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    state_q == bfl_pkg::ST_FEED && cfg_q.mcode_en && pin_lvl[3]
      |=> FEED_O ##1 MFIN_O)
    else $error("no finish signal after reaching position");

  a_clamp_stop: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    state_q == bfl_pkg::ST_FEED && !cfg_q.mcode_en &&
      (pin_lvl[2] == cfg_q.clamp_inv) |=> !FEED_O)
    else $error("feed continued with clamp closed");

  a_eob_short: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    EOB_O && $past(cfg_q.eob_style == bfl_pkg::EOB_SHORT)
      |-> $past(pin_lvl[4]) && !$past(clamp_open))
    else $error("short style end-of-bar with clamp open");

  a_eob_std_clear: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    cfg_q.eob_style == bfl_pkg::EOB_STANDARD && pin_rise[1] && !pin_rise[4]
      |=> !EOB_O)
    else $error("standard end-of-bar not cleared by ejection");

  a_eob_long_hold: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    cfg_q.eob_style == bfl_pkg::EOB_LONG && eob_q && mfin_rise &&
      fin_cnt_q == 2'h0 && !pin_rise[4] |=> EOB_O ##0 fin_cnt_q == 2'h1)
    else $error("long end-of-bar dropped on first finish");

  a_test_order: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    state_q == bfl_pkg::ST_T_CH_UP && motion_done
      |=> MOTION_STEP_O == 3'h4 && TEST_ACTIVE_O)
    else $error("test cycle skipped the flag advance");
endmodule
`default_nettype wire

//--- sim/bfl_lathe_model.sv
// Behavioural lathe and axis sensors facing the bar feeder interface.
// Assumes the bench sets clamp state, polarity and short-bar level.
`timescale 1ns/1ps
`default_nettype none
module bfl_lathe_model (
  input wire logic clk_i,
  input wire logic inv_i,
  input wire logic clamp_open_i,
  input wire logic short_i,
  input wire logic feed_i,
  input wire logic eject_i,
  input wire logic mfin_i,
  input wire logic test_active_i,
  output logic feed_cmd_o,
  output logic eject_cmd_o,
  output logic clamp_o,
  output logic at_pos_o,
  output logic short_o,
  output logic eject_done_o,
  output logic motion_done_o
);
  int pos_cnt;
  int ej_cnt;
  int mo_cnt;

  assign clamp_o = clamp_open_i ^ inv_i;
  assign short_o = short_i;

  initial
  begin
    feed_cmd_o = 1'b0;
    eject_cmd_o = 1'b0;
    at_pos_o = 1'b0;
    eject_done_o = 1'b0;
    motion_done_o = 1'b0;
    pos_cnt = 0;
    ej_cnt = 0;
    mo_cnt = 0;
  end

  // --------------------------------------------------------------------
  // Axis sensors
  // --------------------------------------------------------------------
  // Motion steps finish after a short delay so each step is seen apart.
  always @(posedge clk_i)
  begin
    pos_cnt <= (feed_i === 1'b1) ? pos_cnt + 1 : 0;
    at_pos_o <= (pos_cnt >= 3);
    ej_cnt <= (eject_i === 1'b1) ? ej_cnt + 1 : 0;
    eject_done_o <= (ej_cnt >= 4);
    mo_cnt <= (test_active_i === 1'b1 && mo_cnt < 6) ? mo_cnt + 1 : 0;
    motion_done_o <= (mo_cnt == 6);
  end

  // --------------------------------------------------------------------
  // Static command: held until finish is seen, then a dwell
  // --------------------------------------------------------------------
  task automatic cmd(input bit ej, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    if (ej) eject_cmd_o <= 1'b1;
    else feed_cmd_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (mfin_i !== 1'b1 && n < 200);
    ok = (mfin_i === 1'b1);
    feed_cmd_o <= 1'b0;
    eject_cmd_o <= 1'b0;
  endtask

  task automatic dwell();
    repeat (30) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- sim/bfl_feeder_if_bench.sv
// Self-checking bench for the bar feeder lathe interface.
// Assumes the lathe model file and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "bfl_consts.svh"
module bfl_feeder_if_bench;
  logic clk = 1'b0;
  logic rst_r = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic inv = 1'b0;
  logic opn = 1'b0;
  logic shrt = 1'b0;
  logic fcmd, ecmd, clamp, atpos, sbar, ejd, mod;
  logic feed, ej, mfin, eob, tact;
  logic [2:0] step;
  logic [31:0] rd;
  logic er, ok;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic [2:0] seq [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1};

  always #25 clk = ~clk;

  bfl_feeder_if #(.MFIN_CYCLES(20), .CNT_W(24)) bfl_feeder_if_inst (
    .CLK_I(clk), .RESET_I(rst_r), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FEED_CMD_I(fcmd),
    .EJECT_CMD_I(ecmd), .CLAMP_I(clamp), .AT_POSITION_I(atpos),
    .SHORT_BAR_I(sbar), .EJECT_DONE_I(ejd), .MOTION_DONE_I(mod),
    .FEED_O(feed), .EJECT_O(ej), .MFIN_O(mfin), .EOB_O(eob),
    .TEST_ACTIVE_O(tact), .MOTION_STEP_O(step));

  bfl_lathe_model bfl_lathe_model_inst (
    .clk_i(clk), .inv_i(inv), .clamp_open_i(opn), .short_i(shrt),
    .feed_i(feed), .eject_i(ej), .mfin_i(mfin), .test_active_i(tact),
    .feed_cmd_o(fcmd), .eject_cmd_o(ecmd), .clamp_o(clamp),
    .at_pos_o(atpos), .short_o(sbar), .eject_done_o(ejd),
    .motion_done_o(mod));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic rst();
    @(posedge clk);
    rst_r <= 1'b1;
    wt(12);
    rst_r <= 1'b0;
    wt(1);
  endtask

  task automatic width();
    n = 0;
    while (mfin === 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    miscompares++;
    wrap_up();
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial
  begin
    wt(12);
    rst_r <= 1'b0;
    wt(1);
    apb(1'b0, `BFL_CTRL_OFFS, 32'h0);
    chk("ctrl reset", rd, 32'h22);
    chk("ctrl no err", {31'h0, er}, 32'h0);
    chk("ready", {31'h0, pready}, 32'h1);
    apb(1'b1, `BFL_CTRL_OFFS, 32'h2e);
    apb(1'b0, `BFL_CTRL_OFFS, 32'h0);
    chk("ctrl bad style", rd, 32'h22);
    apb(1'b1, `BFL_STATUS_OFFS, 32'h3ff);
    apb(1'b0, `BFL_STATUS_OFFS, 32'h0);
    chk("status idle", rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers done");
    opn <= 1'b1;
    wt(10);
    chk("feed before cmd", {31'h0, feed}, 32'h0);
    bfl_lathe_model_inst.cmd(1'b0, ok);
    chk("static finish", {31'h0, ok}, 32'h1);
    width();
    chk("static short", {31'h0, n < 20 && n > 0}, 32'h1);
    wt(10);
    chk("hold open", {31'h0, feed}, 32'h1);
    opn <= 1'b0;
    wt(8);
    chk("hold released", {31'h0, feed}, 32'h0);
    bfl_lathe_model_inst.dwell();
    apb(1'b1, `BFL_CTRL_OFFS, 32'h02);
    opn <= 1'b1;
    bfl_lathe_model_inst.cmd(1'b0, ok);
    chk("dynamic finish", {31'h0, ok}, 32'h1);
    width();
    chk("dynamic width", n, 32'd20);
    opn <= 1'b0;
    $display("test mcode done");
    rst();
    inv <= 1'b1;
    apb(1'b1, `BFL_CTRL_OFFS, 32'h10);
    wt(8);
    chk("inv closed", {31'h0, feed}, 32'h0);
    opn <= 1'b1;
    wt(8);
    chk("open feeds", {31'h0, feed}, 32'h1);
    apb(1'b0, `BFL_STATUS_OFFS, 32'h0);
    chk("status open", {31'h0, rd[7]}, 32'h1);
    wt(10);
    chk("no finish", {31'h0, mfin}, 32'h0);
    opn <= 1'b0;
    wt(8);
    chk("close stops", {31'h0, feed}, 32'h0);
    inv <= 1'b0;
    $display("test clamp done");
    rst();
    opn <= 1'b1;
    shrt <= 1'b1;
    wt(10);
    chk("short open", {31'h0, eob}, 32'h0);
    opn <= 1'b0;
    wt(8);
    chk("short closed", {31'h0, eob}, 32'h1);
    shrt <= 1'b0;
    rst();
    apb(1'b1, `BFL_CTRL_OFFS, 32'h2a);
    shrt <= 1'b1;
    wt(8);
    chk("std set", {31'h0, eob}, 32'h1);
    bfl_lathe_model_inst.cmd(1'b1, ok);
    chk("std finish", {31'h0, ok}, 32'h1);
    wt(4);
    chk("std clear", {31'h0, eob}, 32'h0);
    shrt <= 1'b0;
    rst();
    apb(1'b1, `BFL_CTRL_OFFS, 32'h26);
    shrt <= 1'b1;
    wt(8);
    chk("long set", {31'h0, eob}, 32'h1);
    bfl_lathe_model_inst.cmd(1'b1, ok);
    chk("eject finish", {31'h0, ok}, 32'h1);
    wt(4);
    chk("long first", {31'h0, eob}, 32'h1);
    bfl_lathe_model_inst.dwell();
    bfl_lathe_model_inst.cmd(1'b0, ok);
    chk("feed finish", {31'h0, ok}, 32'h1);
    wt(4);
    chk("long second", {31'h0, eob}, 32'h0);
    shrt <= 1'b0;
    $display("test end of bar done");
    rst();
    apb(1'b1, `BFL_CTRL_OFFS, 32'h23);
    for (int i = 0; i < 7; i++)
    begin
      n = 0;
      while (step === (i == 0 ? 3'h0 : seq[i - 1]) && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      chk("test step", {29'h0, step}, {29'h0, seq[i]});
    end
    chk("test active", {31'h0, tact}, 32'h1);
    rst();
    wt(20);
    chk("normal again", {29'h0, step}, 32'h0);
    $display("test running-in done");
    wrap_up();
  end
endmodule
`default_nettype wire
